// ---- design/cmpwm_pkg.sv ----
// Constants, state types and timing figures of the current-mode PWM core.
// Assumes a single 40 MHz clock; every count is derived from it.
// Summary of operation
// - Duty comparator ends on-time via pulse latch
// - Ramp switch closed at duty ceiling, opened when off-delay ends
// - Gate held off about 156 ns after trigger
// - Compensation slope enabled while gate is on
// - Burst mode disables compensation slope
// - Soft start begins at supply turn-on
// - Thirty-two soft-start steps, one per 300 us
// - Soft start ends at 10 ms, sink off
// - Oscillator 100 kHz, jitter swept over 4 ms
// - Duty ceiling is 0.75 of period
// - Jitter enabled only after soft start, 4 kHz
// - Oscillator sets latch; first comparator resets it
// - Latch reset forces gate off at once
// - Gate low while supply is below off-level
// - Peak-limit comparator resets latch immediately
// - Blanking masks peak, burst and amplifier paths
// - Blanking 220 ns normal, 180 ns burst
// - Burst-limit comparator gated only in burst mode
// - Supply drop resets soft-start counter to zero
package cmpwm_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CLK_NS          = 25;

  // ==========================================================================
  // Oscillator.
  localparam int unsigned OSC_HZ          = 100_000;
  localparam int unsigned JITTER_HZ       = 4_000;
  localparam int unsigned JITTER_MS       = 4;
  localparam int unsigned PERIOD_CYC      = CLK_HZ / OSC_HZ;
  localparam int unsigned JIT_CYC         = CLK_HZ / (OSC_HZ + JITTER_HZ) -
                                            PERIOD_CYC + PERIOD_CYC -
                                            CLK_HZ / (OSC_HZ + JITTER_HZ);
  localparam int unsigned JIT_SPAN_CYC    = PERIOD_CYC -
                                            CLK_HZ / (OSC_HZ + JITTER_HZ);
  localparam int unsigned JIT_MS_CYC      = JITTER_MS * (CLK_HZ / 1000);
  localparam int unsigned JIT_STEP_CYC    = JIT_MS_CYC / (4 * JIT_SPAN_CYC);
  localparam int unsigned DMAX_NUM        = 3;
  localparam int unsigned DMAX_DEN        = 4;
  localparam int unsigned DMAX_CYC        = PERIOD_CYC * DMAX_NUM / DMAX_DEN;

  // ==========================================================================
  // Gate-off delay and blanking; least times round up.
  localparam int unsigned TOFF_NS         = 156;
  localparam int unsigned TOFF_CYC        = (TOFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LEB_NORM_NS     = 220;
  localparam int unsigned LEB_BURST_NS    = 180;
  localparam int unsigned LEB_NORM_CYC    = (LEB_NORM_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LEB_BURST_CYC   = (LEB_BURST_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // Soft start.
  localparam int unsigned SS_STEPS        = 32;
  localparam int unsigned SS_STEP_US      = 300;
  localparam int unsigned SS_DONE_MS      = 10;
  localparam int unsigned SS_STEP_CYC     = SS_STEP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SS_DONE_CYC     = SS_DONE_MS * (CLK_HZ / 1000);

  localparam logic [4:0]  SS_LEVEL_RST    = 5'h00;
  localparam logic [4:0]  SS_SINK_RST     = 5'h1F;

  typedef enum logic [1:0] {
    CMPWM_OFF,
    CMPWM_SOFT,
    CMPWM_RUN
  } cmpwm_mode_t;

endpackage : cmpwm_pkg

// ---- design/cmpwm_sync.sv ----
// Two-flop synchroniser bank for asynchronous comparator levels.
// Assumes the inputs are static levels from analog circuitry.
`timescale 1ns/1ps
`default_nettype none
module cmpwm_sync #(
  parameter int unsigned WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // Levels.
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ==========================================================================
  // The first stage is read only by the second stage.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // cmpwm_sync
`default_nettype wire

// ---- design/cmpwm_core.sv ----
// Current-mode PWM core: oscillator, pulse latch, blanking, soft start.
// Assumes the analog comparators and supply detectors drive levels; the
// supply-off detector also drives reset_n_in.
`timescale 1ns/1ps
`default_nettype none
module cmpwm_core
  import cmpwm_pkg::*;
#(
  parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC,
  parameter int unsigned SS_DONE_CYCLES = SS_DONE_CYC,
  parameter int unsigned JIT_STEP_CYCLES = JIT_STEP_CYC
) (
  // Clock and reset; reset is held while supply is below off-level.
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Supply and mode levels.
  input  wire logic       supply_on_in,
  input  wire logic       burst_mode_in,
  // Comparator levels from the analog section.
  input  wire logic       duty_comparator_in,
  input  wire logic       softstart_comparator_in,
  input  wire logic       peak_limit_comparator_in,
  input  wire logic       burst_limit_comparator_in,
  // Gate and analog controls.
  output var  logic       gate_out,
  output var  logic       ramp_switch_out,
  output var  logic       compensation_slope_out,
  output var  logic       spike_blanking_out,
  output var  logic       oscillator_duty_pulse_out,
  output var  logic [4:0] softstart_level_out,
  output var  logic [4:0] softstart_sink_out,
  output var  logic       softstart_done_out
);

  typedef struct packed {
    cmpwm_mode_t mode;
    logic [8:0]  period_cnt;
    logic [8:0]  period_len;
    logic [5:0]  jit_ofs;
    logic        jit_down;
    logic [15:0] jit_cnt;
    logic [19:0] ss_cnt;
    logic [18:0] ss_total;
    logic [4:0]  ss_level;
    logic [4:0]  ss_sink;
    logic        ss_done;
    logic        latch;
    logic [3:0]  toff_cnt;
    logic [3:0]  leb_cnt;
    logic        sup_meta;
    logic        sup_sync;
    logic        gate;
    logic        ramp;
    logic        slope;
    logic        blank;
    logic        osc;
  } cmpwm_state_t;

  cmpwm_state_t s_q;
  cmpwm_state_t s_d;
  logic [3:0]   cmp_sync;
  logic         reset_cond;
  logic         period_end;
  logic         duty_end;
  logic         peak_now;

  // ==========================================================================
  // Synchronised comparator results for the latch reset.
  cmpwm_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_in    (clk_in),
    .reset_n_in(reset_n_in),
    .async_in  ({burst_limit_comparator_in, peak_limit_comparator_in,
                 softstart_comparator_in, duty_comparator_in}),
    .sync_out  (cmp_sync)
  );

  // The raw peak-limit level cuts the gate in the same edge; blanking still
  // masks it so the turn-on spike is ignored.
  assign peak_now = (peak_limit_comparator_in ||
                     (burst_mode_in && burst_limit_comparator_in)) &&
                    !s_q.blank;

  assign period_end = (s_q.period_cnt == s_q.period_len - 9'h001);
  assign duty_end   = (s_q.period_cnt == 9'(DMAX_CYC - 1));

  // ==========================================================================
  always_comb begin
    s_d = s_q;
    s_d.sup_meta = supply_on_in;
    s_d.sup_sync = s_q.sup_meta;
    reset_cond = 1'b0;

    unique case (s_q.mode)
      CMPWM_OFF: begin
        if (s_q.sup_sync) begin
          s_d.mode = CMPWM_SOFT;
          s_d.ss_cnt = '0;
          s_d.ss_total = '0;
          s_d.ss_level = SS_LEVEL_RST;
        end
      end
      CMPWM_SOFT: begin
        s_d.ss_total = s_q.ss_total + 19'h00001;
        if (s_q.ss_cnt == 20'(SS_STEP_CYCLES - 1)) begin
          s_d.ss_cnt = '0;
          if (s_q.ss_level != 5'(SS_STEPS - 1)) begin
            s_d.ss_level = s_q.ss_level + 5'h01;
          end
        end else begin
          s_d.ss_cnt = s_q.ss_cnt + 20'h00001;
        end
        if (s_q.ss_total == 19'(SS_DONE_CYCLES - 1)) begin
          s_d.mode = CMPWM_RUN;
          s_d.ss_done = 1'b1;
          s_d.ss_level = 5'(SS_STEPS - 1);
        end
      end
      CMPWM_RUN: begin
        // Triangle sweep of the period length between -4 kHz and +4 kHz of nominal.
        if (s_q.jit_cnt == 16'(JIT_STEP_CYCLES - 1)) begin
          s_d.jit_cnt = '0;
          if (s_q.jit_down) begin
            if (s_q.jit_ofs == 6'(2 * JIT_SPAN_CYC)) s_d.jit_down = 1'b0;
            else s_d.jit_ofs = s_q.jit_ofs + 6'h01;
          end else begin
            if (s_q.jit_ofs == 6'h00) s_d.jit_down = 1'b1;
            else s_d.jit_ofs = s_q.jit_ofs - 6'h01;
          end
        end else begin
          s_d.jit_cnt = s_q.jit_cnt + 16'h0001;
        end
      end
      default: s_d.mode = CMPWM_OFF;
    endcase

    // Oscillator; period length is latched at each period start. Before
    // normal operation the period stays nominal, so soft start sees no jitter.
    if (s_q.mode == CMPWM_OFF) begin
      s_d.period_cnt = '0;
    end else if (period_end) begin
      s_d.period_cnt = '0;
      if (s_q.mode == CMPWM_RUN) begin
        s_d.period_len = 9'(PERIOD_CYC + JIT_SPAN_CYC) -
                         {3'h0, s_q.jit_ofs};
      end else begin
        s_d.period_len = 9'(PERIOD_CYC);
      end
    end else begin
      s_d.period_cnt = s_q.period_cnt + 9'h001;
    end

    // Pulse latch: set on period start, reset by first comparator.
    s_d.osc = (s_q.period_cnt < 9'(DMAX_CYC)) && (s_q.mode != CMPWM_OFF);
    if (s_q.mode != CMPWM_OFF && period_end) begin
      s_d.latch = 1'b1;
      s_d.toff_cnt = 4'(TOFF_CYC);
      s_d.ramp = 1'b1;
    end else begin
      reset_cond = cmp_sync[0] && !s_q.blank && s_q.toff_cnt == 4'h0
                || cmp_sync[1] && !s_q.blank
                || cmp_sync[2] && !s_q.blank
                || cmp_sync[3] && burst_mode_in && !s_q.blank
                || peak_now || duty_end;
      if (reset_cond) s_d.latch = 1'b0;
      if (duty_end) s_d.ramp = 1'b1;
      if (s_q.toff_cnt != 4'h0) begin
        s_d.toff_cnt = s_q.toff_cnt - 4'h1;
        if (s_q.toff_cnt == 4'h1) s_d.ramp = 1'b0;
      end
    end

    // Gate on only after the off-delay, cut at once when latch resets.
    s_d.gate = s_d.latch && s_d.toff_cnt == 4'h0 &&
               s_q.mode != CMPWM_OFF && s_q.sup_sync;

    // Blanking starts at each switch-on edge.
    if (s_d.gate && !s_q.gate) begin
      s_d.leb_cnt = burst_mode_in ? 4'(LEB_BURST_CYC) :
                                    4'(LEB_NORM_CYC);
    end else if (s_q.leb_cnt != 4'h0) begin
      s_d.leb_cnt = s_q.leb_cnt - 4'h1;
    end
    s_d.blank = (s_d.leb_cnt != 4'h0);

    s_d.slope = s_d.gate && !burst_mode_in;

    // Sink is registered so the output comes straight from a flip-flop.
    s_d.ss_sink = (s_d.mode == CMPWM_OFF || s_d.ss_done) ? 5'h00 :
                  SS_SINK_RST - s_d.ss_level;
  end

  // ==========================================================================
  // Supply loss arrives as reset, which restarts soft start from zero.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '{mode: CMPWM_OFF, period_len: 9'(PERIOD_CYC),
               ss_level: SS_LEVEL_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    gate_out                  = s_q.gate;
    ramp_switch_out           = s_q.ramp;
    compensation_slope_out    = s_q.slope;
    spike_blanking_out        = s_q.blank;
    oscillator_duty_pulse_out = s_q.osc;
    softstart_level_out       = s_q.ss_level;
    softstart_sink_out        = s_q.ss_sink;
    softstart_done_out        = s_q.ss_done;
  end

  // ==========================================================================
  property p_gate_needs_latch;
    @(posedge clk_in) disable iff (!reset_n_in)
      gate_out |-> s_q.latch;
  endproperty
  a_gate_needs_latch: assert property (p_gate_needs_latch)
    else $error("Gate on while latch reset.");

  property p_peak_cuts;
    @(posedge clk_in) disable iff (!reset_n_in)
      (peak_now && !period_end) |=> !gate_out;
  endproperty
  a_peak_cuts: assert property (p_peak_cuts)
    else $error("Peak limit did not cut the gate.");

  property p_toff;
    @(posedge clk_in) disable iff (!reset_n_in)
      (s_q.mode != CMPWM_OFF && period_end) |=> !gate_out [*4];
  endproperty
  a_toff: assert property (p_toff)
    else $error("Gate on within off-delay.");

  property p_slope_burst;
    @(posedge clk_in) disable iff (!reset_n_in)
      compensation_slope_out |-> gate_out && !$past(burst_mode_in);
  endproperty
  a_slope_burst: assert property (p_slope_burst)
    else $error("Slope active without gate or in burst.");

  property p_duty_max;
    @(posedge clk_in) disable iff (!reset_n_in)
      duty_end |=> !gate_out;
  endproperty
  a_duty_max: assert property (p_duty_max)
    else $error("Gate past duty ceiling.");

  property p_jitter_run;
    @(posedge clk_in) disable iff (!reset_n_in)
      (s_q.jit_ofs != 6'h00) |-> s_q.mode == CMPWM_RUN;
  endproperty
  a_jitter_run: assert property (p_jitter_run)
    else $error("Jitter before soft start done.");

  property p_ss_start;
    @(posedge clk_in) disable iff (!reset_n_in)
      (s_q.mode == CMPWM_OFF && s_q.sup_sync) |=>
        s_q.mode == CMPWM_SOFT && softstart_level_out == 5'h00;
  endproperty
  a_ss_start: assert property (p_ss_start)
    else $error("Soft start did not begin at zero.");

  property p_ss_done;
    @(posedge clk_in) disable iff (!reset_n_in)
      softstart_done_out |-> softstart_sink_out == 5'h00;
  endproperty
  a_ss_done: assert property (p_ss_done)
    else $error("Sink still on after soft start.");

  property p_blank_start;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(gate_out) |-> spike_blanking_out;
  endproperty
  a_blank_start: assert property (p_blank_start)
    else $error("No blanking at switch-on.");

  property p_ramp_duty;
    @(posedge clk_in) disable iff (!reset_n_in)
      (duty_end && !period_end) |=> ramp_switch_out;
  endproperty
  a_ramp_duty: assert property (p_ramp_duty)
    else $error("Ramp switch open after duty ceiling.");

  property p_slope_off_burst;
    @(posedge clk_in) disable iff (!reset_n_in)
      burst_mode_in |=> !compensation_slope_out;
  endproperty
  a_slope_off_burst: assert property (p_slope_off_burst)
    else $error("Slope injected in burst mode.");

  property p_jit_range;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_q.period_len >= 9'(PERIOD_CYC - JIT_SPAN_CYC) &&
      s_q.period_len <= 9'(PERIOD_CYC + JIT_SPAN_CYC);
  endproperty
  a_jit_range: assert property (p_jit_range)
    else $error("Period length outside jitter range.");

  property p_nominal_soft;
    @(posedge clk_in) disable iff (!reset_n_in)
      (s_q.mode != CMPWM_RUN) |-> s_q.period_len == 9'(PERIOD_CYC);
  endproperty
  a_nominal_soft: assert property (p_nominal_soft)
    else $error("Period jittered before normal operation.");

endmodule // cmpwm_core
`default_nettype wire

// ---- testbench/cmpwm_far_side.sv ----
// Far side of the core: sense resistor and feedback, seen as comparators.
// Assumes gate_in comes from the core; sense collapses while switch is off.
`timescale 1ns/1ps
`default_nettype none
module cmpwm_far_side (
  // Clock and gate.
  input  wire logic       clk_in,
  input  wire logic       gate_in,
  // Trip points in on-cycles, zero never trips; soft-start level and done flag.
  input  wire logic [8:0] duty_len_in,
  input  wire logic [8:0] peak_len_in,
  input  wire logic [8:0] burst_len_in,
  input  wire logic [4:0] ss_level_in,
  input  wire logic       ss_done_in,
  // Comparator levels.
  output var  logic       duty_out,
  output var  logic       peak_out,
  output var  logic       burst_out,
  output var  logic       ss_out
);
  logic [8:0] on_q = 9'h000;

  always_ff @(posedge clk_in) begin
    on_q <= gate_in ? on_q + 9'h001 : 9'h000;
  end

  // A higher soft-start level lets the sense ramp run longer.
  always_comb begin
    duty_out  = gate_in && duty_len_in != 9'h000 && on_q >= duty_len_in;
    peak_out  = gate_in && peak_len_in != 9'h000 && on_q >= peak_len_in;
    burst_out = gate_in && burst_len_in != 9'h000 && on_q >= burst_len_in;
    ss_out    = gate_in && !ss_done_in &&
                on_q >= {1'b0, ss_level_in, 3'h0} + 9'h010;
  end
endmodule // cmpwm_far_side
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench of the PWM core with a behavioural far side.
// Assumes shortened soft-start and jitter counts given at the instance.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cmpwm_pkg::*;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  fail_count++; $display("wrong value at %0t: %h vs %h", $time, (a), (e)); \
  end end
  logic clk_in, reset_n_in, supply_on_in, burst_mode_in;
  logic duty_c, ss_c, peak_c, burst_c;
  logic gate_out, ramp_switch_out, compensation_slope_out;
  logic spike_blanking_out, oscillator_duty_pulse_out, softstart_done_out;
  logic [4:0] softstart_level_out, softstart_sink_out;
  logic [8:0] duty_len, peak_len, burst_len;
  int   fail_count = 0, total_checks = 0;
  int   on_t, per_t, dly, on_a, mn, mx;
  logic rr, sl, bl;

  cmpwm_core #(.SS_STEP_CYCLES(20), .SS_DONE_CYCLES(700),
    .JIT_STEP_CYCLES(2)) i_cmpwm_core (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .supply_on_in(supply_on_in),
    .burst_mode_in(burst_mode_in), .duty_comparator_in(duty_c),
    .softstart_comparator_in(ss_c), .peak_limit_comparator_in(peak_c),
    .burst_limit_comparator_in(burst_c), .gate_out(gate_out),
    .ramp_switch_out(ramp_switch_out),
    .compensation_slope_out(compensation_slope_out),
    .spike_blanking_out(spike_blanking_out),
    .oscillator_duty_pulse_out(oscillator_duty_pulse_out),
    .softstart_level_out(softstart_level_out),
    .softstart_sink_out(softstart_sink_out),
    .softstart_done_out(softstart_done_out));

  cmpwm_far_side i_cmpwm_far_side (
    .clk_in(clk_in), .gate_in(gate_out), .duty_len_in(duty_len),
    .peak_len_in(peak_len), .burst_len_in(burst_len),
    .ss_level_in(softstart_level_out), .ss_done_in(softstart_done_out),
    .duty_out(duty_c), .peak_out(peak_c), .burst_out(burst_c),
    .ss_out(ss_c));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // ==========================================================================
  // Shared tasks.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Skips the pulse in flight, then measures the next one from its rise.
  task automatic pulse();
    int n;
    n = 0; on_t = 0; per_t = 0; dly = 0;
    while (gate_out !== 1'b0 && n < 2000) begin cyc(1); n++; end
    while (gate_out !== 1'b1 && n < 2000) begin
      cyc(1); n++;
      dly = (oscillator_duty_pulse_out === 1'b1) ? dly + 1 : 0;
    end
    rr = ramp_switch_out;
    sl = compensation_slope_out;
    bl = spike_blanking_out;
    while (gate_out === 1'b1 && n < 2000) begin
      cyc(1); n++; on_t++; per_t++;
    end
    while (gate_out !== 1'b1 && n < 2000) begin cyc(1); n++; per_t++; end
    if (n >= 2000) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic lens(input int d, p, b, input logic bm);
    @(posedge clk_in);
    duty_len <= 9'(d); peak_len <= 9'(p); burst_len <= 9'(b);
    burst_mode_in <= bm;
    pulse();
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    `CHK({gate_out, softstart_done_out, softstart_level_out}, 7'h00)
    @(posedge clk_in) reset_n_in <= 1'b1;
    cyc(50);
    `CHK({gate_out, softstart_level_out}, 6'h00)
    $display("test reset done");
  endtask

  task automatic t_softstart();
    int n;
    n = 0;
    @(posedge clk_in) supply_on_in <= 1'b1;
    while (softstart_level_out !== 5'h01 && n < 100) begin cyc(1); n++; end
    while (softstart_level_out === 5'h01 && n < 100) begin cyc(1); n++; end
    n = 0;
    while (softstart_level_out === 5'h02 && n < 100) begin cyc(1); n++; end
    `CHK(n, 20)
    `CHK(softstart_sink_out, 5'h1F - softstart_level_out)
    pulse();
    on_a = on_t;
    `CHK(per_t, PERIOD_CYC)
    `CHK(dly >= TOFF_CYC - 1 && dly <= TOFF_CYC + 1, 1'b1)
    n = 0;
    while (softstart_done_out !== 1'b1 && n < 1000) begin cyc(1); n++; end
    `CHK(softstart_done_out, 1'b1)
    `CHK(softstart_sink_out, 5'h00)
    $display("test softstart done");
  endtask

  task automatic t_ceiling();
    pulse();
    `CHK(on_a < on_t, 1'b1)
    `CHK(on_t >= DMAX_CYC - TOFF_CYC - 3 && on_t <= DMAX_CYC - TOFF_CYC + 1,
         1'b1)
    `CHK({rr, sl}, 2'b01)
    mn = 1000; mx = 0;
    repeat (16) begin
      pulse();
      if (per_t < mn) mn = per_t;
      if (per_t > mx) mx = per_t;
    end
    `CHK(mn != PERIOD_CYC || mx != PERIOD_CYC, 1'b1)
    `CHK(mn >= PERIOD_CYC * 24 / 25 - 2 && mx <= PERIOD_CYC * 26 / 25 + 2,
         1'b1)
    $display("test ceiling done");
  endtask

  task automatic t_comparators();
    lens(40, 0, 0, 1'b0);
    `CHK(on_t >= 40 && on_t <= 46, 1'b1)
    lens(0, 20, 0, 1'b0);
    `CHK(on_t >= 20 && on_t <= 23, 1'b1)
    lens(0, 2, 0, 1'b0);
    `CHK(on_t >= LEB_NORM_CYC && on_t <= LEB_NORM_CYC + 3, 1'b1)
    `CHK(bl, 1'b1)
    lens(0, 2, 0, 1'b1);
    `CHK(on_t >= LEB_BURST_CYC && on_t <= LEB_BURST_CYC + 3, 1'b1)
    `CHK(sl, 1'b0)
    lens(0, 0, 20, 1'b1);
    `CHK(on_t >= 20 && on_t <= 23, 1'b1)
    lens(0, 0, 20, 1'b0);
    `CHK(on_t > DMAX_CYC - TOFF_CYC - 4, 1'b1)
    `CHK(sl, 1'b1)
    $display("test comparators done");
  endtask

  task automatic t_rereset();
    @(posedge clk_in) reset_n_in <= 1'b0;
    cyc(3);
    `CHK({gate_out, softstart_done_out, softstart_level_out}, 7'h00)
    @(posedge clk_in) reset_n_in <= 1'b1;
    cyc(3);
    `CHK({softstart_done_out, softstart_level_out}, 6'h00)
    cyc(60);
    `CHK(softstart_level_out > 5'h00 && softstart_level_out < 5'h05, 1'b1)
    $display("test rereset done");
  endtask

  initial begin
    reset_n_in = 1'b0; supply_on_in = 1'b0; burst_mode_in = 1'b0;
    duty_len = 9'h000; peak_len = 9'h000; burst_len = 9'h000;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_softstart();
    t_ceiling();
    t_comparators();
    t_rereset();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
